// ---- dv/pin_source.sv ----
// external event and pulse source for the two counter input pins
`timescale 1ns/100ps
`default_nettype none
module pin_source
(
   // clock
   input  wire logic clk,
   // counter input pins
   output logic      pin0,
   output logic      pin1
);
   initial
   begin
      pin0 = 1'b0;
      pin1 = 1'b0;
   end

   // ==========================================================
   // level driver
   // a level lasts at least one cycle more than the cycles asked for; cycles of 0 gives a one-cycle level
   task automatic drive(input int idx, input logic lvl, input int cycles);
      @(posedge clk);
      if (idx == 0)
         pin0 <= lvl;
      else
         pin1 <= lvl;
      repeat (cycles) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the dual timer/event counter
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import tmr_pkg::*;

   localparam int SLOW  = 8;
   localparam int LIMIT = 20000;

   logic        sys_clk = 1'b0;
   logic        rst_b   = 1'b0;
   reg_req_t    bus_req = '0;
   logic [7:0]  rd_data;
   logic        pin0;
   logic        pin1;
   logic        ov0;
   logic        ov1;
   logic        wake;
   logic        flag0;
   logic        flag1;
   int          err_count   = 0;
   int          checks_done = 0;
   int          cyc         = 0;
   int          ov_n[2]     = '{0, 0};
   int          wk_n        = 0;
   logic [31:0] lfsr        = 32'h46ED;
   logic [7:0]  rv;
   logic [15:0] cv;
   logic [15:0] cv2;

   always #2.5 sys_clk = ~sys_clk;

   dual_timer #(.SLOW_DIV_CYCLES(SLOW)) u_dual_timer
   (
      .sys_clk            (sys_clk),
      .rst_b              (rst_b),
      .bus_req            (bus_req),
      .rd_data            (rd_data),
      .counter0_input_pin (pin0),
      .counter1_input_pin (pin1),
      .overflow0          (ov0),
      .overflow1          (ov1),
      .wake_up            (wake),
      .timer0_irq_flag    (flag0),
      .timer1_irq_flag    (flag1)
   );

   pin_source u_pin_source
   (
      .clk  (sys_clk),
      .pin0 (pin0),
      .pin1 (pin1)
   );

   // ==========================================================
   // event counting and hang guard, away from the active edge
   always @(negedge sys_clk)
   begin
      cyc = cyc + 1;
      if (ov0 === 1'b1)
         ov_n[0]++;
      if (ov1 === 1'b1)
         ov_n[1]++;
      if (wake === 1'b1)
         wk_n++;
      if (cyc == LIMIT)
      begin
         err_count++;
         end_of_test();
      end
   end

   // ==========================================================
   // helpers
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // integer reference: count after a number of ticks, reload on overflow
   function automatic int model_count(input int start_val, input int pre, input int ticks);
      int c;
      c = start_val;
      for (int k = 0; k < ticks; k++)
         c = (c == 'hFFFF) ? pre : c + 1;
      return c;
   endfunction

   task automatic end_of_test();
      if (err_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_near(input logic [15:0] got, input int exp, input int tol);
      checks_done++;
      if ((^got === 1'bx) || int'(got) > exp + tol || int'(got) < exp - tol)
      begin
         err_count++;
         $display("wrong value at %0t: count %h, expected %0d", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req.wr    <= 1'b1;
      bus_req.addr  <= a;
      bus_req.wdata <= d;
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus_req.rd   <= 1'b1;
      bus_req.addr <= a;
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      @(negedge sys_clk);
      d = rd_data;
   endtask

   // high byte first: it latches the low byte for the second read
   task automatic rd_cnt(input int t, output logic [15:0] c);
      logic [7:0] h;
      logic [7:0] l;
      rd_reg(OFS_CNT0_HIGH + 8'(3 * t), h);
      rd_reg(OFS_CNT0_LOW + 8'(3 * t), l);
      c = {h, l};
   endtask

   // stop, load preload and counter, then apply the new control value
   task automatic start(input int t, input logic [15:0] p, input logic [7:0] c);
      wr_reg(OFS_CTRL0 + 8'(3 * t), 8'h00);
      wr_reg(OFS_CNT0_LOW + 8'(3 * t), p[7:0]);
      wr_reg(OFS_CNT0_HIGH + 8'(3 * t), p[15:8]);
      wr_reg(OFS_CTRL0 + 8'(3 * t), c);
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd_reg(OFS_CTRL1, rv);
      chk8(rv, CTRL_RESET);
      for (int t = 0; t < 2; t++)
      begin
         wr_reg(OFS_CTRL0 + 8'(3 * t), 8'hFF);
         rd_reg(OFS_CTRL0 + 8'(3 * t), rv);
         chk8(rv, t == 0 ? 8'hDF : 8'hF8);
      end
      lfsr = lfsr_step(lfsr);
      wr_reg(8'h20, lfsr[7:0]);
      rd_reg(8'h20, rv);
      chk8(rv, 8'h00);
      // timer 0 rate for every prescale code
      for (int p = 0; p < 8; p++)
      begin
         start(0, 16'h0000, 8'h90 | 8'(p));
         repeat (512) @(posedge sys_clk);
         wr_reg(OFS_CTRL0, 8'h80);
         rd_cnt(0, cv);
         chk_near(cv, 514 >> p, 2);
      end
      repeat (50) @(posedge sys_clk);
      rd_cnt(0, cv2);
      chk_near(cv2, int'(cv), 0);
      // timer 1 rate for both sources
      for (int s = 0; s < 2; s++)
      begin
         start(1, 16'h0000, 8'h90 | 8'(s << 5));
         repeat (512) @(posedge sys_clk);
         wr_reg(OFS_CTRL1, 8'h80);
         rd_cnt(1, cv);
         chk_near(cv, s == 1 ? 514 / SLOW : 514 / 4, 2);
      end
      // unused mode with run set
      ov_n = '{0, 0};
      start(0, 16'h1234, 8'h17);
      u_pin_source.drive(0, 1'b1, 3);
      u_pin_source.drive(0, 1'b0, 200);
      rd_cnt(0, cv);
      chk_near(cv, 'h1234, 0);
      chk_near(16'(ov_n[0]), 0, 0);
      // timer mode overflow
      wk_n = 0;
      start(0, 16'hFFF0, 8'h90);
      repeat (18) @(posedge sys_clk);
      rd_reg(OFS_CTRL0, rv);
      chk8(rv, 8'h90);
      wr_reg(OFS_CTRL0, 8'h80);
      rd_cnt(0, cv);
      chk_near(cv, model_count('hFFF0, 'hFFF0, 22), 2);
      chk_near(16'(ov_n[0]), 1, 0);
      chk_near(16'(wk_n), 1, 0);
      chk8({7'h00, flag0}, 8'h01);
      rd_reg(OFS_IRQ_FIRST, rv);
      chk8(rv, 8'h40);
      wr_reg(OFS_IRQ_FIRST, 8'h00);
      rd_reg(OFS_IRQ_FIRST, rv);
      chk8(rv, 8'h00);
      // event mode, both edges, random preload
      for (int e = 0; e < 2; e++)
      begin
         lfsr = lfsr_step(lfsr);
         start(0, {1'b0, lfsr[14:0]}, 8'h50 | 8'(e << 3));
         u_pin_source.drive(0, 1'b1, 3);
         rd_cnt(0, cv);
         chk_near(cv, int'(lfsr[14:0]) + int'(e == 0), 0);
         u_pin_source.drive(0, 1'b0, 3);
         wr_reg(OFS_CNT0_LOW, 8'h00);
         wr_reg(OFS_CNT0_HIGH, 8'h00);
         rd_cnt(0, cv);
         chk_near(cv, int'(lfsr[14:0]) + 1, 0);
         wr_reg(OFS_CTRL0, 8'h40 | 8'(e << 3));
         u_pin_source.drive(0, 1'b1, 3);
         u_pin_source.drive(0, 1'b0, 3);
         rd_cnt(0, cv);
         chk_near(cv, int'(lfsr[14:0]) + 1, 0);
      end
      // pulse width, both polarities; pin already at active level first
      for (int e = 0; e < 2; e++)
      begin
         u_pin_source.drive(0, 1'(e), 2);
         start(0, 16'h0000, 8'hD0 | 8'(e << 3));
         repeat (10) @(posedge sys_clk);
         rd_cnt(0, cv);
         chk_near(cv, 0, 0);
         u_pin_source.drive(0, 1'(e == 0), 2);
         u_pin_source.drive(0, 1'(e), 39);
         u_pin_source.drive(0, 1'(e == 0), 5);
         rd_reg(OFS_CTRL0, rv);
         chk8(rv, 8'hC0 | 8'(e << 3));
         rd_cnt(0, cv);
         chk_near(cv, 40, 2);
         u_pin_source.drive(0, 1'(e), 9);
         u_pin_source.drive(0, 1'(e == 0), 5);
         rd_cnt(0, cv2);
         chk_near(cv2, int'(cv), 0);
      end
      // pulse mode overflow on timer 1
      ov_n = '{0, 0};
      start(1, 16'hFFF8, 8'hD8);
      u_pin_source.drive(1, 1'b1, 47);
      u_pin_source.drive(1, 1'b0, 5);
      rd_cnt(1, cv);
      chk_near(cv, model_count('hFFF8, 'hFFF8, 12), 2);
      chk_near(16'(ov_n[1]), 1, 0);
      rd_reg(OFS_IRQ_SECOND, rv);
      chk8(rv, 8'h10);
      chk8({7'h00, flag1}, 8'h01);
      end_of_test();
   end
endmodule
`default_nettype wire

// ---- include/tmr_pkg.sv ----
// shared constants and types for the dual timer/event counter
package tmr_pkg;

   // ==========================================================
   // clocking
   localparam int unsigned SYS_CLK_HZ   = 200_000_000;
   localparam int unsigned SLOW_CLK_HZ  = 32768;
   // rounds down; the slow tick runs a hair fast
   localparam int unsigned SLOW_DIV     = SYS_CLK_HZ / SLOW_CLK_HZ;
   localparam logic [1:0]  FAST_DIV_END = 2'h3;

   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_CNT0_HIGH  = 8'h0C;
   localparam logic [7:0] OFS_CNT0_LOW   = 8'h0D;
   localparam logic [7:0] OFS_CTRL0      = 8'h0E;
   localparam logic [7:0] OFS_CNT1_HIGH  = 8'h0F;
   localparam logic [7:0] OFS_CNT1_LOW   = 8'h10;
   localparam logic [7:0] OFS_CTRL1      = 8'h11;
   localparam logic [7:0] OFS_IRQ_FIRST  = 8'h12;
   localparam logic [7:0] OFS_IRQ_SECOND = 8'h13;

   // ==========================================================
   // fields and reset values
   localparam int unsigned IRQ0_FLAG_POS = 6;
   localparam int unsigned IRQ1_FLAG_POS = 4;
   localparam logic [7:0]  CTRL0_MASK    = 8'hDF;
   localparam logic [7:0]  CTRL1_MASK    = 8'hF8;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [15:0] CNT_RESET     = 16'h0000;
   localparam logic [15:0] CNT_MAX       = 16'hFFFF;

   localparam logic [1:0] MODE_OFF   = 2'b00;
   localparam logic [1:0] MODE_EVENT = 2'b01;
   localparam logic [1:0] MODE_TIMER = 2'b10;
   localparam logic [1:0] MODE_PULSE = 2'b11;

   // ==========================================================
   // types
   typedef struct packed {
      logic [1:0] mode;
      logic       source;
      logic       run;
      logic       edge_sel;
      logic [2:0] psc;
   } ctrl_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic {PW_WAIT, PW_MEASURE} pw_state_t;

endpackage

// ---- rtl/count_core.sv ----
// 16-bit up counter with preload and overflow reload
`timescale 1ns/100ps
`default_nettype none
module count_core
   import tmr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // control
   input  wire logic        tick,
   input  wire logic        running,
   input  wire logic        wr_pre,
   input  wire logic [15:0] pre_val,
   // state
   output logic [15:0]      count,
   output logic [15:0]      preload,
   output logic             overflow
);
   logic [15:0] next_count;
   logic [15:0] next_preload;
   logic        next_overflow;

   always_comb
   begin
      next_count    = count;
      next_preload  = preload;
      next_overflow = 1'b0;
      if (wr_pre)
      begin
         next_preload = pre_val;
         if (!running)
            next_count = pre_val;
      end
      if (tick)
      begin
         if (count == CNT_MAX)
         begin
            next_count    = preload;
            next_overflow = 1'b1;
         end
         else
            next_count = count + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count    <= CNT_RESET;
         preload  <= CNT_RESET;
         overflow <= 1'b0;
      end
      else
      begin
         count    <= next_count;
         preload  <= next_preload;
         overflow <= next_overflow;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/dual_timer.sv ----
// two 16-bit timer/event counters with register port
`timescale 1ns/100ps
`default_nettype none
module dual_timer
   import tmr_pkg::*;
#(
   parameter int unsigned SLOW_DIV_CYCLES = SLOW_DIV
)
(
   // clock and reset
   input  wire logic     sys_clk,
   input  wire logic     rst_b,
   // register port
   input  wire reg_req_t bus_req,
   output logic [7:0]    rd_data,
   // counter input pins
   input  wire logic     counter0_input_pin,
   input  wire logic     counter1_input_pin,
   // overflow events
   output logic          overflow0,
   output logic          overflow1,
   output logic          wake_up,
   output logic          timer0_irq_flag,
   output logic          timer1_irq_flag
);
   localparam int SLOW_W = $clog2(SLOW_DIV_CYCLES + 1);
   localparam logic [SLOW_W-1:0] SLOW_END = SLOW_W'(SLOW_DIV_CYCLES - 1);

   // ==========================================================
   // reset release
   logic [1:0] rst_pipe;
   logic       rst_n;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         rst_pipe <= 2'b00;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_n = rst_pipe[1];

   // ==========================================================
   // internal count clocks
   logic [6:0]        psc_cnt;
   logic [6:0]        next_psc_cnt;
   logic [6:0]        psc_mask;
   logic [1:0]        fast_cnt;
   logic [1:0]        next_fast_cnt;
   logic [SLOW_W-1:0] slow_cnt;
   logic [SLOW_W-1:0] next_slow_cnt;
   logic              fast_tick;
   logic              slow_tick;
   logic [1:0]        int_tick;
   ctrl_t             ctrl [2];

   always_comb
   begin
      next_psc_cnt  = psc_cnt + 7'h01;
      next_fast_cnt = fast_cnt + 2'h1;
      next_slow_cnt = (slow_cnt == SLOW_END) ? '0 : slow_cnt + SLOW_W'(1);
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         psc_cnt  <= 7'h00;
         fast_cnt <= 2'h0;
         slow_cnt <= '0;
      end
      else
      begin
         psc_cnt  <= next_psc_cnt;
         fast_cnt <= next_fast_cnt;
         slow_cnt <= next_slow_cnt;
      end
   end

   // tick once every 2^psc cycles
   assign psc_mask    = 7'((8'h01 << ctrl[0].psc) - 8'h01);
   assign int_tick[0] = &(psc_cnt | ~psc_mask);
   assign fast_tick   = (fast_cnt == FAST_DIV_END);
   assign slow_tick   = (slow_cnt == SLOW_END);
   assign int_tick[1] = ctrl[1].source ? slow_tick : fast_tick;

   // ==========================================================
   // per timer logic
   logic [1:0]  pins;
   logic [1:0]  rise;
   logic [1:0]  fall;
   logic [1:0]  cnt_tick;
   logic [1:0]  wr_pre;
   logic [1:0]  ctrl_wr;
   logic [1:0]  pw_stop;
   logic [1:0]  ovf;
   logic [15:0] cnt [2];
   logic [15:0] preload [2];
   logic [7:0]  lowbuf [2];
   pw_state_t   pw [2];

   assign pins = {counter1_input_pin, counter0_input_pin};

   for (genvar i = 0; i < 2; i++)
   begin : g_tmr
      localparam logic [7:0] OFS_HIGH = (i == 0) ? OFS_CNT0_HIGH : OFS_CNT1_HIGH;
      localparam logic [7:0] OFS_LOW  = (i == 0) ? OFS_CNT0_LOW : OFS_CNT1_LOW;
      localparam logic [7:0] OFS_CTRL = (i == 0) ? OFS_CTRL0 : OFS_CTRL1;
      localparam logic [7:0] MASK     = (i == 0) ? CTRL0_MASK : CTRL1_MASK;

      ctrl_t     next_ctrl;
      logic [7:0] next_lowbuf;
      pw_state_t next_pw;
      logic      start_edge;
      logic      stop_edge;
      logic      pw_on;

      edge_detect u_edge
      (
         .clk  (sys_clk),
         .rst_n(rst_n),
         .pin  (pins[i]),
         .rise (rise[i]),
         .fall (fall[i])
      );

      assign wr_pre[i]  = bus_req.wr && (bus_req.addr == OFS_HIGH);
      assign ctrl_wr[i] = bus_req.wr && (bus_req.addr == OFS_CTRL);
      assign start_edge = ctrl[i].edge_sel ? rise[i] : fall[i];
      assign stop_edge  = ctrl[i].edge_sel ? fall[i] : rise[i];
      assign pw_on      = ctrl[i].run && (ctrl[i].mode == MODE_PULSE);

      // tick selection by mode
      always_comb
      begin
         unique case (ctrl[i].mode)
            MODE_EVENT: cnt_tick[i] = ctrl[i].run &&
                           (ctrl[i].edge_sel ? fall[i] : rise[i]);
            MODE_TIMER: cnt_tick[i] = ctrl[i].run && int_tick[i];
            MODE_PULSE: cnt_tick[i] = pw_on && (pw[i] == PW_MEASURE) &&
                           int_tick[i];
            MODE_OFF:   cnt_tick[i] = 1'b0;
         endcase
      end

      // pulse width sequencing, armed by run together with pulse mode
      always_comb
      begin
         next_pw    = pw[i];
         pw_stop[i] = 1'b0;
         if (!pw_on)
            next_pw = PW_WAIT;
         else
         begin
            unique case (pw[i])
               PW_WAIT:
                  if (start_edge)
                     next_pw = PW_MEASURE;
               PW_MEASURE:
                  if (stop_edge)
                  begin
                     pw_stop[i] = 1'b1;
                     next_pw    = PW_WAIT;
                  end
            endcase
         end
      end

      always_comb
      begin
         next_ctrl   = ctrl[i];
         next_lowbuf = lowbuf[i];
         if (pw_stop[i])
            next_ctrl.run = 1'b0;
         if (ctrl_wr[i])
            next_ctrl = ctrl_t'(bus_req.wdata & MASK);
         if (bus_req.wr && (bus_req.addr == OFS_LOW))
            next_lowbuf = bus_req.wdata;
         if (bus_req.rd && (bus_req.addr == OFS_HIGH))
            next_lowbuf = cnt[i][7:0];
      end

      always_ff @(posedge sys_clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            ctrl[i]   <= ctrl_t'(CTRL_RESET);
            lowbuf[i] <= 8'h00;
            pw[i]     <= PW_WAIT;
         end
         else
         begin
            ctrl[i]   <= next_ctrl;
            lowbuf[i] <= next_lowbuf;
            pw[i]     <= next_pw;
         end
      end

      count_core u_core
      (
         .clk     (sys_clk),
         .rst_n   (rst_n),
         .tick    (cnt_tick[i]),
         .running (ctrl[i].run),
         .wr_pre  (wr_pre[i]),
         .pre_val ({bus_req.wdata, lowbuf[i]}),
         .count   (cnt[i]),
         .preload (preload[i]),
         .overflow(ovf[i])
      );
   end

   // ==========================================================
   // request flags, wake-up and read port
   logic       next_irq0;
   logic       next_irq1;
   logic       next_wake;
   logic [7:0] next_rd;

   always_comb
   begin
      next_irq0 = timer0_irq_flag;
      next_irq1 = timer1_irq_flag;
      if (bus_req.wr && (bus_req.addr == OFS_IRQ_FIRST))
         next_irq0 = bus_req.wdata[IRQ0_FLAG_POS];
      if (bus_req.wr && (bus_req.addr == OFS_IRQ_SECOND))
         next_irq1 = bus_req.wdata[IRQ1_FLAG_POS];
      // set wins over a clearing write
      if (ovf[0])
         next_irq0 = 1'b1;
      if (ovf[1])
         next_irq1 = 1'b1;
      next_wake = ovf[0] | ovf[1];
      next_rd   = 8'h00;
      if (bus_req.rd)
      begin
         unique case (bus_req.addr)
            OFS_CNT0_HIGH:  next_rd = cnt[0][15:8];
            OFS_CNT0_LOW:   next_rd = lowbuf[0];
            OFS_CTRL0:      next_rd = ctrl[0] & CTRL0_MASK;
            OFS_CNT1_HIGH:  next_rd = cnt[1][15:8];
            OFS_CNT1_LOW:   next_rd = lowbuf[1];
            OFS_CTRL1:      next_rd = ctrl[1] & CTRL1_MASK;
            OFS_IRQ_FIRST:  next_rd = 8'(timer0_irq_flag) << IRQ0_FLAG_POS;
            OFS_IRQ_SECOND: next_rd = 8'(timer1_irq_flag) << IRQ1_FLAG_POS;
            default:        next_rd = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timer0_irq_flag <= 1'b0;
         timer1_irq_flag <= 1'b0;
         wake_up         <= 1'b0;
         rd_data         <= 8'h00;
      end
      else
      begin
         timer0_irq_flag <= next_irq0;
         timer1_irq_flag <= next_irq1;
         wake_up         <= next_wake;
         rd_data         <= next_rd;
      end
   end

   assign overflow0 = ovf[0];
   assign overflow1 = ovf[1];

   // ==========================================================
   // assertions
   logic pw_on_0;
   assign pw_on_0 = ctrl[0].run && ctrl[0].mode == MODE_PULSE;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_run_gates_count: assert property (
      !ctrl[0].run && !wr_pre[0] |=> cnt[0] == $past(cnt[0]))
      else $error("count moved while stopped");

   a_off_mode_idle: assert property (
      ctrl[1].mode == MODE_OFF && !wr_pre[1] |=> !ovf[1] && $stable(cnt[1]))
      else $error("unused mode counted");

   a_ovf_reload: assert property (
      cnt_tick[0] && cnt[0] == CNT_MAX |=> ovf[0] && cnt[0] == $past(preload[0]))
      else $error("overflow did not reload");

   a_irq_flag_set: assert property (
      ovf[0] |=> timer0_irq_flag)
      else $error("request flag not set");

   a_pw_clears_run: assert property (
      pw_stop[0] && !ctrl_wr[0] |=> !ctrl[0].run)
      else $error("run not cleared after pulse");

   a_run_kept_sw: assert property (
      ctrl[1].run && ctrl[1].mode != MODE_PULSE && !ctrl_wr[1] |=> ctrl[1].run)
      else $error("run cleared by hardware");

   a_pw_result_hold: assert property (
      pw_stop[0] ##1 (!wr_pre[0] && !ctrl_wr[0])[*3] |-> cnt[0] == $past(cnt[0], 2))
      else $error("measured count changed");

   a_pw_edge_start: assert property (
      pw_on_0 && pw[0] == PW_WAIT && !(ctrl[0].edge_sel ? rise[0] : fall[0])
      |=> pw[0] == PW_WAIT)
      else $error("measurement began without edge");

   a_event_edge: assert property (
      ctrl[0].mode == MODE_EVENT && ctrl[0].run |-> cnt_tick[0] ==
      (ctrl[0].edge_sel ? fall[0] : rise[0]))
      else $error("wrong edge counted");

   a_psc_divides: assert property (
      int_tick[0] && ctrl[0].psc != 3'h0 && !ctrl_wr[0] |=> !int_tick[0])
      else $error("prescaler ticked twice");

   a_fast_div4: assert property (
      fast_tick |=> (!fast_tick)[*3] ##1 fast_tick)
      else $error("slow by four divider wrong");

   a_wake_source: assert property (
      ovf[0] || ovf[1] |=> wake_up)
      else $error("no wake-up on overflow");

   a_preload_load: assert property (
      wr_pre[0] && !ctrl[0].run |=> cnt[0] == {$past(bus_req.wdata), $past(lowbuf[0])})
      else $error("stopped preload write lost");

   a_ctrl_unused: assert property (
      bus_req.rd && bus_req.addr == OFS_CTRL0 |=> rd_data[5] == 1'b0)
      else $error("unused bit read as one");

   c_pulse_done:  cover property (pw[0] == PW_MEASURE ##[1:300] pw_stop[0]);
   c_timer_ovf:   cover property (ctrl[1].mode == MODE_TIMER && ovf[1]);
   c_event_count: cover property (ctrl[0].mode == MODE_EVENT && cnt_tick[0]);
endmodule
`default_nettype wire

// ---- rtl/edge_detect.sv ----
// registered input pin with rising and falling edge pulses
`timescale 1ns/100ps
`default_nettype none
module edge_detect
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // pin and edges
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);
   logic prev;
   logic primed;

   // no edge before the first sample is known
   assign rise = primed & pin & ~prev;
   assign fall = primed & ~pin & prev;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev   <= 1'b0;
         primed <= 1'b0;
      end
      else
      begin
         prev   <= pin;
         primed <= 1'b1;
      end
   end
endmodule
`default_nettype wire
